/* tb/lsa_panel_model.sv */
// Panel-side timing source: frame pulse, then a run of line pulses
`timescale 1ns/1ps
`default_nettype none

module lsa_panel_model #(
    parameter int LINE_W = 10,
    parameter int LINES  = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              run,
    input  wire logic              slow,
    output logic                   frame_pulse,
    output logic                   line_pulse,
    output logic [LINE_W-1:0]      line_num,
    output logic                   busy
);
    logic [2:0]        gap;
    logic [LINE_W-1:0] idx;

    // One frame per start; prompt mode gives line pulses back to back
    always_ff @(posedge clk) begin
        frame_pulse <= 1'b0;
        line_pulse  <= 1'b0;
        line_num    <= ~line_num; // Line number means nothing off the pulse
        if (rst) begin
            busy     <= 1'b0;
            gap      <= 3'h0;
            idx      <= '0;
            line_num <= '0;
        end else if (!busy) begin
            if (run) begin
                frame_pulse <= 1'b1;
                busy        <= 1'b1;
                idx         <= '0;
                gap         <= 3'h1;
            end
        end else if (gap != 3'h0) begin
            gap <= gap - 3'h1;
        end else begin
            line_pulse <= 1'b1;
            line_num   <= idx;
            idx        <= idx + 1'b1;
            gap        <= slow ? 3'h5 : 3'h0;
            if (idx == LINE_W'(LINES - 1)) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : lsa_panel_model

`default_nettype wire

/* tb/lsa_top_tb.sv */
// Self-checking bench for the AC-bias and screen start block
`timescale 1ns/1ps
`default_nettype none

module lsa_top_tb;
    import lsa_pkg::*;
    logic         clk, rst, run, slow, pas, rot, chk, fp, lp, ac, busy;
    logic         ac_d, lp_d;
    logic [9:0]   split, ln, ln_d;
    logic [15:0]  p1, p2, c1, c2;
    lsa_apb_req_t req;
    lsa_apb_rsp_t rsp;
    lsa_fetch_t   fet;
    int           failures, comparisons, nfp, nlp, ntog, cyc;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    lsa_top #(.LINE_W(10)) i_lsa_top (
        .SYS_CLK(clk), .RESET(rst), .APB_REQ(req), .APB_RSP(rsp),
        .FRAME_PULSE(fp), .LINE_PULSE(lp), .PASSIVE_PANEL(pas),
        .ROTATED_VIEW_MODE(rot), .SPLIT_LINE(split), .LINE_NUM(ln),
        .AC_BIAS_TOGGLE(ac), .FETCH(fet));

    lsa_panel_model #(.LINE_W(10), .LINES(8)) i_lsa_panel_model (
        .clk(clk), .rst(rst), .run(run), .slow(slow), .frame_pulse(fp),
        .line_pulse(lp), .line_num(ln), .busy(busy));

    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_fetch(input lsa_fetch_t g, input lsa_fetch_t e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_fetch

    // Expected fetch start for a line, from the active start values
    function automatic lsa_fetch_t exp_f(input logic [9:0] n);
        lsa_fetch_t f;
        f.screen2   = n > split;
        f.byte_addr = rot;
        f.start     = f.screen2 ? c2 : c1;
        if (!rot) f.start[15] = 1'b0;
        return f;
    endfunction : exp_f

    // Counters, active start model, fetch checks and the hang limit
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            tally_and_finish();
        end
        ac_d <= ac;
        lp_d <= lp;
        ln_d <= ln;
        if (fp === 1'b1) begin
            nfp++;
            c1 <= p1;
            c2 <= p2;
        end
        if (lp === 1'b1) nlp++;
        if (!rst && ac !== ac_d) ntog++;
        if (chk && lp_d === 1'b1) cmp_fetch(fet, exp_f(ln_d));
    end

    // One APB transfer; waits for pready, only the bench limit ends a hang
    task automatic apb(input logic w, input logic [15:0] ix,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, {ix, 2'b00}, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] ix, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ix, d, r, e);
    endtask : wr

    task automatic rdc(input logic [15:0] ix, input logic [31:0] d,
                       input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, ix, 32'h0, r, e);
        cmp_word(r, d);
        cmp_word({31'h0, e}, {31'h0, ee});
    endtask : rdc

    // Run whole frames, then wait for the panel to go idle
    task automatic run_fr(input int k, input logic s);
        int t;
        t = nfp + k;
        slow <= s;
        run  <= 1'b1;
        wait (nfp >= t);
        @(posedge clk);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        wait (busy === 1'b0);
        repeat (4) @(posedge clk);
    endtask : run_fr

    task automatic t_regs;
        logic [15:0] ix[6];
        ix = '{IDX_AC_BIAS_RATE, IDX_S1_START_LO, IDX_S1_START_HI,
               IDX_S2_START_LO, IDX_S2_START_HI, IDX_STATUS};
        foreach (ix[i]) rdc(ix[i], 32'h0, 1'b0);
        rdc(16'hFFEE, 32'h0, 1'b1);
        wr(IDX_AC_BIAS_RATE, 32'h0000_00FF);
        rdc(IDX_AC_BIAS_RATE, 32'h0000_003F, 1'b0);
        wr(IDX_S2_START_HI, 32'h0000_01B4);
        rdc(IDX_S2_START_HI, 32'h0000_00B4, 1'b0);
    endtask : t_regs

    task automatic t_ac(input logic [5:0] n, input int fr, input logic s);
        pas <= 1'b0;
        wr(IDX_AC_BIAS_RATE, {26'h0, n});
        pas <= 1'b1;
        @(posedge clk);
        ntog = 0;
        nlp  = 0;
        nfp  = 0;
        run_fr(fr, s);
        cmp_word(nlp, fr * 8);
        if (n == 6'h0) cmp_word(ntog, fr);
        else cmp_word(ntog, fr * 8 / (n + 1));
    endtask : t_ac

    task automatic t_active;
        pas <= 1'b0;
        wr(IDX_AC_BIAS_RATE, 32'h0000_0002);
        @(posedge clk);
        ntog = 0;
        run_fr(2, 1'b0);
        cmp_word(ntog, 0);
        cmp_word({31'h0, ac}, 32'h0);
    endtask : t_active

    task automatic t_fetch;
        int t;
        split <= 10'd3;
        wr(IDX_S1_START_LO, 32'h0000_0023);
        wr(IDX_S1_START_HI, 32'h0000_00C1);
        wr(IDX_S2_START_HI, 32'h0000_00B4);
        wr(IDX_S2_START_LO, 32'h0000_0056);
        p1  = 16'hC123;
        p2  = 16'hB456;
        chk = 1'b1;
        run_fr(1, 1'b0);
        rot <= 1'b1;
        run_fr(1, 1'b1);
        // A start written mid-frame waits for the next frame pulse
        t = nfp;
        slow <= 1'b1;
        run  <= 1'b1;
        wait (nfp > t);
        wr(IDX_S1_START_HI, 32'h0000_007E);
        p1 = 16'h7E23;
        run_fr(1, 1'b1);
        chk = 1'b0;
    endtask : t_fetch

    // Reset, then each scenario in turn
    initial begin
        rst = 1'b1;
        {run, slow, pas, rot, chk} = 5'h00;
        split = '0;
        req   = '0;
        {p1, p2, c1, c2} = 64'h0;
        {failures, comparisons, nfp, nlp, ntog, cyc} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_ac(6'd0, 3, 1'b0);
        t_ac(6'd1, 2, 1'b1);
        t_ac(6'd3, 3, 1'b0);
        t_ac(6'd63, 8, 1'b1);
        t_active;
        t_fetch;
        tally_and_finish;
    end
endmodule : lsa_top_tb

`default_nettype wire

/* verilog/lsa_pkg.sv */
// Package: register map, field layout, reset values and bus carriers
package lsa_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_AC_BIAS_RATE = 16'hFFEB;
    localparam logic [15:0] IDX_S1_START_LO  = 16'hFFEC;
    localparam logic [15:0] IDX_S1_START_HI  = 16'hFFED;
    localparam logic [15:0] IDX_S2_START_LO  = 16'hFFEF;
    localparam logic [15:0] IDX_S2_START_HI  = 16'hFFF0;
    localparam logic [15:0] IDX_STATUS       = 16'hFF80;

    // Field layout
    localparam int RATE_W      = 6;
    localparam int START_W     = 16;
    localparam int LAND_MSB    = 14;
    localparam int BYTE_W      = 8;
    localparam int ST_AC_BIT   = 0;
    localparam int ST_SEL2_BIT = 1;
    localparam int ST_BYTE_BIT = 2;
    localparam int ST_PASS_BIT = 3;

    // Reset values
    localparam logic [5:0]  RATE_RST  = 6'h00;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Bus widths
    localparam int PADDR_W = 18;
    localparam int PDATA_W = 32;

    // APB request from the master
    typedef struct packed {
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [PDATA_W-1:0] pwdata;
    } lsa_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic               pready;
        logic               pslverr;
        logic [PDATA_W-1:0] prdata;
    } lsa_apb_rsp_t;

    // Line fetch start handed to the refresh engine
    typedef struct packed {
        logic               screen2;
        logic               byte_addr;
        logic [START_W-1:0] start;
    } lsa_fetch_t;

endpackage : lsa_pkg

/* verilog/lsa_top.sv */
// AC-bias toggle and split-screen start address block with APB registers
//
// How it works
// R1 - With a rate of zero the AC-bias output inverts on every frame pulse.
// R2 - With a non-zero rate N the AC-bias output inverts after N+1 line pulses.
// R3 - The rate only applies to passive panels; on active panels the output is held low and the line count cleared.
// R4 - In landscape the 15-bit Screen 1 start is a word address.
// R5 - In rotated view the Screen 1 start is a byte address.
// R6 - In landscape the 15-bit Screen 2 start is a word address.
// R7 - In rotated view the Screen 2 start is a byte address.
// R8 - Screen 2 start bit 15 is used in rotated view and ignored in landscape.
// R9 - Lines 0 to the split count come from Screen 1, the rest from Screen 2.
// R10 - Low and high bytes form one 16-bit start, taken at the next frame.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lsa_top #(
    parameter int LINE_W = 10
) (
    input  wire logic                 SYS_CLK,
    input  wire logic                 RESET,
    input  wire lsa_pkg::lsa_apb_req_t APB_REQ,
    output var  lsa_pkg::lsa_apb_rsp_t APB_RSP,
    input  wire logic                 FRAME_PULSE,
    input  wire logic                 LINE_PULSE,
    input  wire logic                 PASSIVE_PANEL,
    input  wire logic                 ROTATED_VIEW_MODE,
    input  wire logic [LINE_W-1:0]    SPLIT_LINE,
    input  wire logic [LINE_W-1:0]    LINE_NUM,
    output logic                      AC_BIAS_TOGGLE,
    output var  lsa_pkg::lsa_fetch_t  FETCH
);
    import lsa_pkg::*;

    // Refuse line counters too narrow or too wide for a panel
    if (LINE_W < 2 || LINE_W > 16) begin : g_chk
        $error("LINE_W out of range");
    end

    // Complete state of the block
    typedef struct packed {
        lsa_apb_rsp_t       rsp;
        logic [RATE_W-1:0]  rate;
        logic [START_W-1:0] s1;
        logic [START_W-1:0] s2;
        logic [START_W-1:0] s1_act;
        logic [START_W-1:0] s2_act;
        logic [RATE_W-1:0]  line_cnt;
        logic               ac_bias;
        lsa_fetch_t         fetch;
    } lsa_state_t;

    lsa_state_t st_reg;
    lsa_state_t st_next;

    logic               access;
    logic               take;
    logic [15:0]        idx;
    logic               mapped;
    logic [PDATA_W-1:0] rd_val;
    logic [BYTE_W-1:0]  wbyte;
    logic [3:0]         status;

    // Bus decode: word aligned index compare
    assign access = APB_REQ.psel & APB_REQ.penable;
    assign take   = access & st_reg.rsp.pready;
    assign idx    = APB_REQ.paddr[PADDR_W-1:2];
    assign wbyte  = APB_REQ.pwdata[BYTE_W-1:0];

    // Live block state shown to software
    always_comb begin
        status              = 4'h0;
        status[ST_AC_BIT]   = st_reg.ac_bias;
        status[ST_SEL2_BIT] = st_reg.fetch.screen2;
        status[ST_BYTE_BIT] = st_reg.fetch.byte_addr;
        status[ST_PASS_BIT] = PASSIVE_PANEL;
    end

    // Read multiplexer; unmapped or unaligned reads give zero
    always_comb begin
        mapped = 1'b1;
        rd_val = RDATA_RST;
        if (APB_REQ.paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else begin
            unique case (idx)
                IDX_AC_BIAS_RATE: rd_val[RATE_W-1:0] = st_reg.rate;
                IDX_S1_START_LO:  rd_val[7:0] = st_reg.s1[7:0];
                IDX_S1_START_HI:  rd_val[7:0] = st_reg.s1[15:8];
                IDX_S2_START_LO:  rd_val[7:0] = st_reg.s2[7:0];
                IDX_S2_START_HI:  rd_val[7:0] = st_reg.s2[15:8];
                IDX_STATUS:       rd_val[3:0] = status;
                default:          mapped = 1'b0;
            endcase
        end
    end

    // Next state of the whole block
    always_comb begin
        st_next = st_reg;

        // One wait cycle, answer with ready for one cycle
        st_next.rsp.pready = access & ~st_reg.rsp.pready;
        if (access & ~st_reg.rsp.pready) begin
            st_next.rsp.pslverr = ~mapped;
            st_next.rsp.prdata  = APB_REQ.pwrite ? RDATA_RST : rd_val;
        end else begin
            st_next.rsp.pslverr = 1'b0;
            st_next.rsp.prdata  = RDATA_RST;
        end

        // Writes land at the completing edge only
        if (take & APB_REQ.pwrite & mapped) begin
            unique case (idx)
                IDX_AC_BIAS_RATE: st_next.rate = wbyte[RATE_W-1:0];
                IDX_S1_START_LO:  st_next.s1[7:0] = wbyte; // R10
                IDX_S1_START_HI:  st_next.s1[15:8] = wbyte; // R10
                IDX_S2_START_LO:  st_next.s2[7:0] = wbyte; // R10
                IDX_S2_START_HI:  st_next.s2[15:8] = wbyte; // R10
                default:          st_next.rate = st_reg.rate;
            endcase
        end

        // Start addresses take effect at the next frame
        if (FRAME_PULSE) begin
            st_next.s1_act = st_reg.s1; // R10
            st_next.s2_act = st_reg.s2; // R10
        end

        // AC-bias toggle generation
        if (!PASSIVE_PANEL) begin
            st_next.ac_bias  = 1'b0; // R3
            st_next.line_cnt = '0; // R3
        end else if (st_reg.rate == RATE_RST) begin
            st_next.line_cnt = '0;
            if (FRAME_PULSE) begin
                st_next.ac_bias = ~st_reg.ac_bias; // R1
            end
        end else if (LINE_PULSE) begin
            if (st_reg.line_cnt >= st_reg.rate) begin
                st_next.ac_bias  = ~st_reg.ac_bias; // R2
                st_next.line_cnt = '0; // R2
            end else begin
                st_next.line_cnt = RATE_W'(st_reg.line_cnt + 6'h01); // R2
            end
        end

        // Per-line start selection for the coming line
        if (LINE_PULSE) begin
            st_next.fetch.screen2   = LINE_NUM > SPLIT_LINE; // R9
            st_next.fetch.byte_addr = ROTATED_VIEW_MODE; // R5 R7
            if (LINE_NUM > SPLIT_LINE) begin
                if (ROTATED_VIEW_MODE) begin
                    st_next.fetch.start = st_reg.s2_act; // R7 R8
                end else begin
                    st_next.fetch.start =
                        {1'b0, st_reg.s2_act[LAND_MSB:0]}; // R6 R8
                end
            end else begin
                if (ROTATED_VIEW_MODE) begin
                    st_next.fetch.start = st_reg.s1_act; // R5
                end else begin
                    st_next.fetch.start =
                        {1'b0, st_reg.s1_act[LAND_MSB:0]}; // R4
                end
            end
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_reg.rsp.pready  <= 1'b0;
            st_reg.rsp.pslverr <= 1'b0;
            st_reg.rsp.prdata  <= RDATA_RST;
            st_reg.rate        <= RATE_RST;
            st_reg.s1          <= START_RST;
            st_reg.s2          <= START_RST;
            st_reg.s1_act      <= START_RST;
            st_reg.s2_act      <= START_RST;
            st_reg.line_cnt    <= RATE_RST;
            st_reg.ac_bias     <= 1'b0;
            st_reg.fetch       <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign APB_RSP        = st_reg.rsp;
    assign AC_BIAS_TOGGLE = st_reg.ac_bias;
    assign FETCH          = st_reg.fetch;

    // Checks on the block's own behaviour
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_wait;
        access && !st_reg.rsp.pready;
    endsequence

    sequence s_answer;
        st_reg.rsp.pready ##1 !st_reg.rsp.pready;
    endsequence

    property p_apb_answer;
        s_wait |=> s_answer;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB answer not one cycle after access");

    property p_frame_toggle;
        PASSIVE_PANEL && st_reg.rate == 6'h00 && FRAME_PULSE
            |=> AC_BIAS_TOGGLE != $past(AC_BIAS_TOGGLE);
    endproperty
    a_frame_toggle: assert property (p_frame_toggle) // R1
        else $error("AC bias missed frame toggle");

    property p_frame_hold;
        PASSIVE_PANEL && st_reg.rate == 6'h00 && !FRAME_PULSE
            |=> $stable(AC_BIAS_TOGGLE);
    endproperty
    a_frame_hold: assert property (p_frame_hold) // R1
        else $error("AC bias moved without frame pulse");

    property p_line_toggle;
        PASSIVE_PANEL && st_reg.rate != 6'h00 && LINE_PULSE
            && st_reg.line_cnt == st_reg.rate
            |=> AC_BIAS_TOGGLE != $past(AC_BIAS_TOGGLE)
                && st_reg.line_cnt == 6'h00;
    endproperty
    a_line_toggle: assert property (p_line_toggle) // R2
        else $error("AC bias missed line toggle");

    property p_line_hold;
        PASSIVE_PANEL && st_reg.rate != 6'h00
            && !(LINE_PULSE && st_reg.line_cnt >= st_reg.rate)
            |=> $stable(AC_BIAS_TOGGLE);
    endproperty
    a_line_hold: assert property (p_line_hold) // R2
        else $error("AC bias toggled early");

    property p_active_quiet;
        !PASSIVE_PANEL |=> !AC_BIAS_TOGGLE;
    endproperty
    a_active_quiet: assert property (p_active_quiet) // R3
        else $error("AC bias active on active panel");

    property p_land_s1;
        LINE_PULSE && !ROTATED_VIEW_MODE && LINE_NUM <= SPLIT_LINE
            |=> FETCH.start == {1'b0, $past(st_reg.s1_act[14:0])}
                && !FETCH.screen2 && !FETCH.byte_addr;
    endproperty
    a_land_s1: assert property (p_land_s1) // R4
        else $error("Landscape Screen 1 start wrong");

    property p_rot_s1;
        LINE_PULSE && ROTATED_VIEW_MODE && LINE_NUM <= SPLIT_LINE
            |=> FETCH.start == $past(st_reg.s1_act) && FETCH.byte_addr;
    endproperty
    a_rot_s1: assert property (p_rot_s1) // R5
        else $error("Rotated Screen 1 start wrong");

    property p_land_s2;
        LINE_PULSE && !ROTATED_VIEW_MODE && LINE_NUM > SPLIT_LINE
            |=> FETCH.start == {1'b0, $past(st_reg.s2_act[14:0])}
                && FETCH.screen2;
    endproperty
    a_land_s2: assert property (p_land_s2) // R6
        else $error("Landscape Screen 2 start wrong");

    property p_rot_s2;
        LINE_PULSE && ROTATED_VIEW_MODE && LINE_NUM > SPLIT_LINE
            |=> FETCH.start == $past(st_reg.s2_act)
                && FETCH.screen2 && FETCH.byte_addr;
    endproperty
    a_rot_s2: assert property (p_rot_s2) // R7
        else $error("Rotated Screen 2 start wrong");

    property p_split_hold;
        !LINE_PULSE |=> $stable(FETCH);
    endproperty
    a_split_hold: assert property (p_split_hold) // R9
        else $error("Fetch start changed between lines");

    property p_shadow_take;
        FRAME_PULSE |=> st_reg.s1_act == $past(st_reg.s1)
            && st_reg.s2_act == $past(st_reg.s2);
    endproperty
    a_shadow_take: assert property (p_shadow_take) // R10
        else $error("Start address not taken at frame");

    property p_shadow_hold;
        !FRAME_PULSE |=> $stable(st_reg.s1_act) && $stable(st_reg.s2_act);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) // R10
        else $error("Start address changed mid-frame");

    sequence s_wr_take;
        take && APB_REQ.pwrite && mapped;
    endsequence

    sequence s_bad_access;
        access && !st_reg.rsp.pready && !mapped;
    endsequence

    property p_rsp_idle;
        !st_reg.rsp.pready |-> !APB_RSP.pslverr
            && APB_RSP.prdata == RDATA_RST;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle)
        else $error("APB answer fields set outside pready");

    property p_bad_access;
        s_bad_access |=> APB_RSP.pslverr && APB_RSP.prdata == RDATA_RST;
    endproperty
    a_bad_access: assert property (p_bad_access)
        else $error("Unmapped access not refused");

    property p_rate_write;
        s_wr_take ##0 (idx == IDX_AC_BIAS_RATE)
            |=> st_reg.rate == $past(wbyte[RATE_W-1:0]);
    endproperty
    a_rate_write: assert property (p_rate_write) // R2
        else $error("Rate write did not land");

    property p_s1_write;
        s_wr_take ##0 (idx == IDX_S1_START_HI)
            |=> st_reg.s1[15:8] == $past(wbyte)
                && $stable(st_reg.s1[7:0]);
    endproperty
    a_s1_write: assert property (p_s1_write) // R10
        else $error("Screen 1 high byte write did not land");

    property p_s2_write;
        s_wr_take ##0 (idx == IDX_S2_START_LO)
            |=> st_reg.s2[7:0] == $past(wbyte)
                && $stable(st_reg.s2[15:8]);
    endproperty
    a_s2_write: assert property (p_s2_write) // R10
        else $error("Screen 2 low byte write did not land");

    property p_line_count;
        PASSIVE_PANEL && st_reg.rate != 6'h00 && LINE_PULSE
            && st_reg.line_cnt < st_reg.rate
            |=> st_reg.line_cnt == $past(st_reg.line_cnt) + 6'h01
                && $stable(AC_BIAS_TOGGLE);
    endproperty
    a_line_count: assert property (p_line_count) // R2
        else $error("Line pulse count did not advance");

    property p_active_clear;
        !PASSIVE_PANEL |=> st_reg.line_cnt == 6'h00;
    endproperty
    a_active_clear: assert property (p_active_clear) // R3
        else $error("Line count kept on active panel");

endmodule : lsa_top

`default_nettype wire
